// ---- include/flash_cmd_map.svh ----
`ifndef FLASH_CMD_MAP_SVH
`define FLASH_CMD_MAP_SVH
`define REG_STATUS 2'h0
`define REG_COMMAND 2'h1
`define REG_ADDR_LO 2'h2
`define REG_ADDR_HI 2'h3
`define BIT_CBEF 7
`define BIT_CCF 6
`define BIT_PVIOL 5
`define BIT_ACCERR 4
`define BIT_BLANK 2
`define CMD_BLANK 8'h05
`define CMD_BYTE 8'h20
`define CMD_BURST 8'h25
`define CMD_PAGE 8'h40
`define CMD_MASS 8'h41
`define ERASED_BYTE 8'hFF
`define SEC_UNSECURED 2'h2
`define KEY_LO 16'hFFB0
`define KEY_HI 16'hFFB7
`endif

// ---- include/flash_cmd_pkg.sv ----
package flash_cmd_pkg;
    typedef enum logic [2:0] {
        CMD_NONE, CMD_BLANKCHK, CMD_BYTEPROG, CMD_BURSTPROG, CMD_PAGEERASE, CMD_MASSERASE
    } cmd_kind_e;
    typedef enum {S_IDLE, S_RUN} seq_state_e;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] data;
        cmd_kind_e kind;
    } array_op_s;
endpackage

// ---- design/flash_command_status_unit.sv ----
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "flash_cmd_map.svh"
module flash_command_status_unit
    import flash_cmd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [1:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    input wire logic arrayWrite,
    input wire logic [15:0] arrayAddr,
    input wire logic [7:0] arrayData,
    input wire logic dividerSet,
    input wire logic stopMode,
    input wire logic keyWriteEnable,
    input wire logic protectDisable,
    input wire logic [15:0] protectBoundary,
    output array_op_s arrayOp,
    output logic arrayStart,
    input wire logic arrayDone,
    input wire logic arrayByte,
    input wire logic [7:0] arrayRdByte,
    output logic [1:0] securityStateCode,
    output logic securityUpdate
);
    seq_state_e state, next_state;
    logic cbef, next_cbef, ccfBusy;
    logic pviol, next_pviol, accerr, next_accerr, blank, next_blank;
    logic haveAddr, next_haveAddr, haveCmd, next_haveCmd;
    logic pendValid, next_pendValid;
    logic [15:0] latAddr, next_latAddr;
    logic [7:0] latData, next_latData, cmdCode, next_cmdCode;
    cmd_kind_e latKind, next_latKind;
    array_op_s curOp, next_curOp, pendOp, next_pendOp;
    logic allErased, next_allErased;
    logic [7:0] rdData, next_rdData;
    logic [1:0] secCode, next_secCode;
    logic secUpd, next_secUpd, startPulse, next_startPulse;
    logic wrStatus, wrCommand, launch, protHit, decodeOk;
    cmd_kind_e decoded;

    always_comb begin
        unique case (cmdCode)
            `CMD_BLANK: decoded = CMD_BLANKCHK;
            `CMD_PAGE: decoded = CMD_PAGEERASE;
            `CMD_MASS: decoded = CMD_MASSERASE;
            `CMD_BYTE: decoded = CMD_BYTEPROG;
            `CMD_BURST: decoded = CMD_BURSTPROG;
            default: decoded = CMD_NONE;
        endcase
    end
    assign decodeOk = decoded != CMD_NONE;
    // Boundary marks the lowest unprotected address at the high end; mass erase hits whenever protectDisable is low
    assign protHit = !protectDisable && (decoded == CMD_MASSERASE
        || (decoded != CMD_BLANKCHK && latAddr < protectBoundary));
    assign wrStatus = regWrite && regAddr == `REG_STATUS;
    assign wrCommand = regWrite && regAddr == `REG_COMMAND;
    assign launch = wrStatus && regWrData[`BIT_CBEF] && !cbef ? 1'b0
        : wrStatus && regWrData[`BIT_CBEF];
    assign ccfBusy = state == S_RUN || pendValid;

    always_comb begin
        next_state = state;
        next_cbef = cbef;
        next_pviol = pviol;
        next_accerr = accerr;
        next_blank = blank;
        next_haveAddr = haveAddr;
        next_haveCmd = haveCmd;
        next_pendValid = pendValid;
        next_latAddr = latAddr;
        next_latData = latData;
        next_cmdCode = cmdCode;
        next_latKind = latKind;
        next_curOp = curOp;
        next_pendOp = pendOp;
        next_allErased = allErased;
        next_secCode = secCode;
        next_secUpd = 1'b0;
        next_startPulse = 1'b0;
        next_rdData = 8'h00;
        if (regRead) begin
            unique case (regAddr)
                `REG_STATUS: next_rdData = {cbef, !ccfBusy, pviol, accerr, 1'b0, blank,
                    2'b00};
                `REG_COMMAND: next_rdData = cmdCode;
                `REG_ADDR_LO: next_rdData = latAddr[7:0];
                `REG_ADDR_HI: next_rdData = latAddr[15:8];
            endcase
        end
        // Key window writes are compare-key writes when enabled, not sequence starts
        if (arrayWrite && !(keyWriteEnable && arrayAddr >= `KEY_LO
            && arrayAddr <= `KEY_HI)) begin
            if (!cbef) begin
                next_accerr = 1'b1;
            end else begin
                next_haveAddr = 1'b1;
                next_haveCmd = 1'b0;
                next_latAddr = arrayAddr;
                next_latData = arrayData;
            end
        end
        if (wrCommand) begin
            if (!haveAddr || !cbef) begin
                next_accerr = 1'b1;
            end else begin
                next_cmdCode = regWrData;
                next_haveCmd = 1'b1;
            end
        end
        if (wrStatus && regWrData[`BIT_PVIOL]) begin
            next_pviol = 1'b0;
        end
        if (wrStatus && regWrData[`BIT_ACCERR]) begin
            next_accerr = 1'b0;
        end
        if (launch) begin
            next_haveAddr = 1'b0;
            next_haveCmd = 1'b0;
            if (!haveCmd || !haveAddr) begin
                next_accerr = 1'b1;
            end else if (!decodeOk) begin
                next_accerr = 1'b1;
            end else if (!dividerSet && decoded != CMD_BLANKCHK) begin
                next_accerr = 1'b1;
            end else if (ccfBusy && (decoded != CMD_BURSTPROG
                || curOp.kind != CMD_BURSTPROG)) begin
                next_accerr = 1'b1;
            end else if (protHit) begin
                next_pviol = 1'b1;
            end else begin
                next_blank = 1'b0;
                next_cbef = 1'b0;
                if (state == S_RUN) begin
                    next_pendValid = 1'b1;
                    next_pendOp = '{addr: latAddr, data: latData, kind: decoded};
                end else begin
                    next_curOp = '{addr: latAddr, data: latData, kind: decoded};
                    next_allErased = 1'b1;
                    next_startPulse = 1'b1;
                    next_state = S_RUN;
                end
            end
        end
        if (state == S_RUN) begin
            if (arrayByte && arrayRdByte != `ERASED_BYTE) begin
                next_allErased = 1'b0;
            end
            if (stopMode) begin
                next_accerr = 1'b1;
                next_pendValid = 1'b0;
                next_cbef = 1'b1;
                next_state = S_IDLE;
            end else if (arrayDone) begin
                if (curOp.kind == CMD_BLANKCHK
                    && !(arrayByte && arrayRdByte != `ERASED_BYTE) && allErased) begin
                    next_blank = 1'b1;
                    next_secCode = `SEC_UNSECURED;
                    next_secUpd = 1'b1;
                end
                if (pendValid) begin
                    next_curOp = pendOp;
                    next_pendValid = 1'b0;
                    next_startPulse = 1'b1;
                    next_cbef = 1'b1;
                end else begin
                    next_state = S_IDLE;
                    next_cbef = 1'b1;
                end
            end else if (!pendValid && !cbef && !launch && curOp.kind == CMD_BURSTPROG) begin
                // Only a running burst frees the buffer early; others refuse new launches
                next_cbef = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state <= S_IDLE;
            cbef <= 1'b1;
            pviol <= 1'b0;
            accerr <= 1'b0;
            blank <= 1'b0;
            haveAddr <= 1'b0;
            haveCmd <= 1'b0;
            pendValid <= 1'b0;
            latAddr <= 16'h0000;
            latData <= 8'h00;
            cmdCode <= 8'h00;
            latKind <= CMD_NONE;
            curOp <= '0;
            pendOp <= '0;
            allErased <= 1'b0;
            secCode <= 2'b00;
            secUpd <= 1'b0;
            startPulse <= 1'b0;
            rdData <= 8'h00;
        end else begin
            state <= next_state;
            cbef <= next_cbef;
            pviol <= next_pviol;
            accerr <= next_accerr;
            blank <= next_blank;
            haveAddr <= next_haveAddr;
            haveCmd <= next_haveCmd;
            pendValid <= next_pendValid;
            latAddr <= next_latAddr;
            latData <= next_latData;
            cmdCode <= next_cmdCode;
            latKind <= next_latKind;
            curOp <= next_curOp;
            pendOp <= next_pendOp;
            allErased <= next_allErased;
            secCode <= next_secCode;
            secUpd <= next_secUpd;
            startPulse <= next_startPulse;
            rdData <= next_rdData;
        end
    end

    assign regRdData = rdData;
    assign arrayOp = curOp;
    assign arrayStart = startPulse;
    assign securityStateCode = secCode;
    assign securityUpdate = secUpd;

    chk_busy_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
        startPulse |-> state == S_RUN) else $error("start without run state");
    chk_launch_clears: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state == S_IDLE && !startPulse && next_startPulse) |=> !cbef && state == S_RUN)
        else $error("launch did not mark busy");
    chk_pviol_sticky: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (pviol && !(wrStatus && regWrData[`BIT_PVIOL])) |=> pviol)
        else $error("violation flag lost");
    chk_accerr_sticky: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (accerr && !(wrStatus && regWrData[`BIT_ACCERR])) |=> accerr)
        else $error("access error lost");
    chk_illegal_code: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (launch && haveCmd && haveAddr && !decodeOk) |=> accerr && !startPulse)
        else $error("illegal code not refused");
    chk_prot_drop: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (launch && haveCmd && haveAddr && decodeOk && dividerSet && !ccfBusy && protHit)
        |=> pviol && !startPulse) else $error("protected command ran");
    chk_early_launch: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (launch && !haveCmd) |=> accerr) else $error("early launch not flagged");
    chk_blank_secure: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $rose(blank) |-> secCode == `SEC_UNSECURED && secUpd)
        else $error("blank without unsecure");
    chk_blank_cmd: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $rose(blank) |-> $past(curOp.kind) == CMD_BLANKCHK) else $error("blank from other op");
    cov_burst_queue: cover property (@(posedge sys_clk) pendValid && state == S_RUN);
    cov_blank_done: cover property (@(posedge sys_clk) $rose(blank));
    cov_pviol: cover property (@(posedge sys_clk) $rose(pviol));
endmodule

// ---- test/flash_command_status_unit_test.sv ----
`timescale 1ns/1ps
`include "flash_cmd_map.svh"
module flash_command_status_unit_test;
    import flash_cmd_pkg::*;
    logic sys_clk = 0, sys_rst = 1, regWrite = 0, regRead = 0, arrayWrite = 0;
    logic dividerSet = 1, stopMode = 0, keyWriteEnable = 0, protectDisable = 0;
    logic arrayDone = 0, arrayByte = 0, arrayStart, securityUpdate;
    logic [1:0] regAddr = 0, securityStateCode;
    logic [15:0] arrayAddr = 0, protectBoundary = 0;
    logic [7:0] regWrData = 0, arrayData = 0, arrayRdByte = 0, regRdData;
    array_op_s arrayOp;
    int error_cnt = 0, compares = 0, cycles = 0;

    flash_command_status_unit flash_command_status_unit_inst (.sys_clk(sys_clk),
        .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
        .regRead(regRead), .regRdData(regRdData), .arrayWrite(arrayWrite),
        .arrayAddr(arrayAddr), .arrayData(arrayData), .dividerSet(dividerSet),
        .stopMode(stopMode), .keyWriteEnable(keyWriteEnable),
        .protectDisable(protectDisable), .protectBoundary(protectBoundary),
        .arrayOp(arrayOp), .arrayStart(arrayStart), .arrayDone(arrayDone),
        .arrayByte(arrayByte), .arrayRdByte(arrayRdByte),
        .securityStateCode(securityStateCode), .securityUpdate(securityUpdate));

    always #12.5 sys_clk = ~sys_clk;

    // Whole run needs well under 1000 cycles; the ceiling only catches hangs
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 4000) begin
            error_cnt++;
            $display("unexpected %0t run did not finish", $time);
            summarize();
        end
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp, input string m);
        chk8({7'h00, got}, {7'h00, exp}, m);
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1;
        @(posedge sys_clk);
        regWrite <= 0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] exp, input string m);
        @(posedge sys_clk);
        regAddr <= `REG_STATUS;
        regRead <= 1;
        @(posedge sys_clk);
        regRead <= 0;
        #1 chk8(regRdData, exp, m);
    endtask

    task automatic launch(input logic [15:0] a, input logic [7:0] c, input logic cmd);
        @(posedge sys_clk);
        arrayWrite <= 1;
        arrayAddr <= a;
        arrayData <= 8'h5A;
        @(posedge sys_clk);
        arrayWrite <= 0;
        if (cmd) wr(`REG_COMMAND, c);
        wr(`REG_STATUS, 8'h80);
        #1;
    endtask

    task automatic done();
        @(posedge sys_clk);
        arrayDone <= 1;
        @(posedge sys_clk);
        arrayDone <= 0;
    endtask

    task automatic bytes(input logic [7:0] b0, input logic [7:0] b1);
        @(posedge sys_clk);
        arrayByte <= 1;
        arrayRdByte <= b0;
        @(posedge sys_clk);
        arrayRdByte <= b1;
        @(posedge sys_clk);
        arrayByte <= 0;
    endtask

    task automatic waitStart();
        logic got;
        got = 0;
        for (int i = 0; i < 4; i++) begin
            #1 if (arrayStart === 1'b1) got = 1;
            @(posedge sys_clk);
        end
        chk1(got, 1, "queued burst start");
    endtask

    task automatic tCodes();
        logic [7:0] codes [4] = '{`CMD_BYTE, `CMD_BURST, `CMD_PAGE, `CMD_MASS};
        cmd_kind_e kinds [4] = '{CMD_BYTEPROG, CMD_BURSTPROG, CMD_PAGEERASE, CMD_MASSERASE};
        protectDisable <= 1;
        rd(8'hC0, "idle status");
        for (int i = 0; i < 4; i++) begin
            launch(16'h8000, codes[i], 1);
            chk1(arrayStart, 1, "start");
            chk8({5'h00, arrayOp.kind}, {5'h00, kinds[i]}, "kind");
            chk8(arrayOp.data, 8'h5A, "data");
            wr(`REG_STATUS, 8'h40);
            rd(kinds[i] == CMD_BURSTPROG ? 8'h80 : 8'h00, "running");
            done();
            rd(8'hC0, "complete");
        end
        protectDisable <= 0;
    endtask

    task automatic tErrors();
        launch(16'h8000, 8'h33, 1);
        chk1(arrayStart, 0, "illegal start");
        wr(`REG_STATUS, 8'h00);
        rd(8'hD0, "illegal code");
        wr(`REG_STATUS, 8'h10);
        rd(8'hC0, "accerr cleared");
        launch(16'h8000, 8'h00, 0);
        chk1(arrayStart, 0, "no command start");
        rd(8'hD0, "launch without command");
        wr(`REG_STATUS, 8'h10);
        dividerSet <= 0;
        launch(16'h8000, `CMD_BYTE, 1);
        chk1(arrayStart, 0, "no divider start");
        rd(8'hD0, "no divider");
        wr(`REG_STATUS, 8'h10);
        dividerSet <= 1;
        launch(16'h8000, `CMD_BYTE, 1);
        @(posedge sys_clk);
        stopMode <= 1;
        @(posedge sys_clk);
        stopMode <= 0;
        rd(8'hD0, "stop aborts");
        wr(`REG_STATUS, 8'h10);
        keyWriteEnable <= 1;
        launch(16'hFFB0, `CMD_BYTE, 1);
        chk1(arrayStart, 0, "key write start");
        rd(8'hD0, "key write not a sequence");
        keyWriteEnable <= 0;
        wr(`REG_STATUS, 8'h10);
    endtask

    task automatic tProtect();
        protectBoundary <= 16'h4000;
        launch(16'h1000, `CMD_BYTE, 1);
        chk1(arrayStart, 0, "protected start");
        wr(`REG_STATUS, 8'h10);
        rd(8'hE0, "pviol kept");
        wr(`REG_STATUS, 8'h20);
        rd(8'hC0, "pviol cleared");
        protectDisable <= 1;
        launch(16'h1000, `CMD_BYTE, 1);
        chk1(arrayStart, 1, "unprotected start");
        done();
        protectDisable <= 0;
        protectBoundary <= 16'h0000;
    endtask

    task automatic tBlank();
        dividerSet <= 0;
        launch(16'h0000, `CMD_BLANK, 1);
        chk1(arrayStart, 1, "blank start");
        bytes(8'hFF, 8'hFF);
        done();
        #1 chk1(securityUpdate, 1, "security update");
        rd(8'hC4, "blank set");
        chk8({6'h00, securityStateCode}, {6'h00, `SEC_UNSECURED}, "security");
        wr(`REG_STATUS, 8'h04);
        rd(8'hC4, "blank write ignored");
        launch(16'h0000, `CMD_BLANK, 1);
        rd(8'h00, "blank cleared on launch");
        bytes(8'hFF, 8'hFE);
        done();
        rd(8'hC0, "not blank");
        dividerSet <= 1;
    endtask

    task automatic tBurst();
        launch(16'h8000, `CMD_BURST, 1);
        launch(16'h8001, `CMD_BURST, 1);
        rd(8'h00, "buffer full");
        done();
        waitStart();
        chk8(arrayOp.addr[7:0], 8'h01, "queued address");
        rd(8'h80, "buffer empty again");
        launch(16'h8002, `CMD_BYTE, 1);
        rd(8'h90, "byte while busy");
        done();
        rd(8'hD0, "after burst");
        wr(`REG_STATUS, 8'h10);
    endtask

    task automatic summarize();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge sys_clk);
        sys_rst <= 0;
        tCodes();
        tErrors();
        tProtect();
        tBlank();
        tBurst();
        summarize();
    end
endmodule
